// ---- core/dsc_cfg.svh ----
// deep standby control: register offsets, field positions, counts
// assumes: included by the device end and the host end
`ifndef DSC_CFG_SVH
`define DSC_CFG_SVH
`define DSC_REG_ANA2     5'h13
`define DSC_REG_STBY     5'h14
`define DSC_BIT_SLOWOSC  0
`define DSC_BIT_TDLY     1
`define DSC_BIT_RXTOFF   2
`define DSC_BIT_ENABLE   3
`define DSC_BIT_SHADOW   4
`define DSC_BIT_MANUAL   5
`define DSC_BIT_METHOD   6
`define DSC_STBY_MASK    16'h007F
`define DSC_ANA_NV_MASK  16'h0303
`define DSC_RST_STBY     16'h0000
`define DSC_RST_ANA2     16'h0000
`define DSC_PRE_LEN      6'h20
`define DSC_HDR_LAST     5'h0C
`define DSC_DATA_LAST    5'h0F
`define DSC_TA_LAST      5'h01
`define DSC_OP_WR        2'h1
`define DSC_OP_RD        2'h2
`define DSC_START        2'h1
`define DSC_TA_WR        2'h2
`define DSC_FRAME_LAST   6'h3F
`define DSC_TA_IDX       6'h2E
`define DSC_DATA_IDX     6'h30
`define DSC_DLY_MIN      16'h0010
`define DSC_DLY_LONG     16'h0400
`define DSC_MDC_HALF     8'h04
`define DSC_RST_HOLD     8'h10
`endif

// ---- core/dsc_pkg.sv ----
// deep standby control: state encodings and state records of both ends
// assumes: dsc_cfg.svh is on the include path
package dsc_pkg;
  typedef enum logic [1:0] {
    DSC_D_IDLE = 2'b00,
    DSC_D_HDR  = 2'b01,
    DSC_D_TA   = 2'b10,
    DSC_D_DATA = 2'b11
  } dsc_dev_st_t;

  typedef enum logic [1:0] {
    DSC_H_IDLE  = 2'b00,
    DSC_H_FRAME = 2'b01,
    DSC_H_RST   = 2'b10
  } dsc_host_st_t;

  typedef struct packed {
    logic        mdcS1;
    logic        mdcS2;
    logic        mdcS3;
    logic        mdioS1;
    logic        mdioS2;
    logic        enS1;
    logic        enS2;
    dsc_dev_st_t st;
    logic [5:0]  pre;
    logic [4:0]  cnt;
    logic [12:0] hdr;
    logic [15:0] sh;
    logic        isRead;
    logic [4:0]  regAd;
    logic [15:0] ana2;
    logic [15:0] stby;
    logic [10:0] nvCopy;
    logic [15:0] lossCnt;
    logic        manLatch;
    logic        standby;
    logic        indicator;
    logic        slowSel;
    logic        rxTermOff;
    logic        shadowEn;
    logic        mdioOut;
    logic        mdioOeN;
  } dsc_dev_s_t;

  typedef struct packed {
    dsc_host_st_t st;
    logic [7:0]   div;
    logic [5:0]   idx;
    logic [31:0]  frame;
    logic         isRead;
    logic         mdioS1;
    logic         mdioS2;
    logic         mdc;
    logic         mdioOut;
    logic         mdioOeN;
    logic         cmdReady;
    logic         rdValid;
    logic [15:0]  rdData;
    logic         devReset;
  } dsc_host_s_t;
endpackage

// ---- core/dsc_mdio_if.sv ----
// management link between host end and device end
// assumes: open-drain style wire with a pull-up, resolved here
`timescale 1ns/10ps
interface dsc_mdio_if;
  logic mdc;
  logic hostOut;
  logic hostOeN;
  logic devOut;
  logic devOeN;
  logic mdio;

  // wire level from the two enables; idle line pulls high
  assign mdio = !hostOeN ? hostOut : (!devOeN ? devOut : 1'b1);

  modport host (output mdc, output hostOut, output hostOeN, input mdio);
  modport dev  (input mdc, input mdio, output devOut, output devOeN);
endinterface

// ---- core/dsc_device.sv ----
// deep standby control, device end: management slave plus standby logic
// assumes: mdc/mdio and cable energy arrive asynchronously; rst is the
// hardware reset, the only way out of commanded standby
`timescale 1ns/10ps
`include "dsc_cfg.svh"
module dsc_device #(
  parameter logic [4:0]  PHY_ADDR = 5'h00,
  parameter logic [15:0] DLY_MIN  = `DSC_DLY_MIN,
  parameter logic [15:0] DLY_LONG = `DSC_DLY_LONG
) (
  input  wire logic        clk,
  input  wire logic        rst,
  dsc_mdio_if.dev          mg,
  input  wire logic        energyDetect,
  output logic             energyIndicatorOut,
  output logic             standbyActive,
  output logic             slowOscSel,
  output logic             rxTermOff,
  output logic             shadowEn,
  output logic [10:0]      shadowWord
);
  if (DLY_MIN == 16'h0000 || DLY_LONG < DLY_MIN) begin : gBadDly
    $error("dsc_device: delays must be nonzero and long not below minimum");
  end

  dsc_pkg::dsc_dev_s_t r_ff;
  dsc_pkg::dsc_dev_s_t nxt_r;

  // ************************************************
  // ** combinational next state
  // ************************************************
  logic        rise;
  logic        bitIn;
  logic [12:0] newHdr;
  logic [15:0] rdVal;
  logic [15:0] limit;
  logic        lost;
  logic        frozen;
  logic        en;
  logic        autoSleep;

  always_comb begin
    nxt_r     = r_ff;
    nxt_r.mdcS1  = mg.mdc;
    nxt_r.mdcS2  = r_ff.mdcS1;
    nxt_r.mdcS3  = r_ff.mdcS2;
    nxt_r.mdioS1 = mg.mdio;
    nxt_r.mdioS2 = r_ff.mdioS1;
    nxt_r.enS1   = energyDetect;
    nxt_r.enS2   = r_ff.enS1;
    rise      = r_ff.mdcS2 & ~r_ff.mdcS3;
    bitIn     = r_ff.mdioS2;
    newHdr    = {r_ff.hdr[11:0], bitIn};
    rdVal     = 16'h0000;
    if (newHdr[4:0] == `DSC_REG_ANA2) begin
      rdVal = r_ff.ana2;
    end else if (newHdr[4:0] == `DSC_REG_STBY) begin
      rdVal = r_ff.stby & `DSC_STBY_MASK;
    end
    // no clock reaches management logic in standby without the slow oscillator
    frozen = r_ff.standby & ~r_ff.ana2[`DSC_BIT_SLOWOSC];

    if (frozen) begin
      nxt_r.st      = dsc_pkg::DSC_D_IDLE;
      nxt_r.pre     = 6'h00;
      nxt_r.mdioOeN = 1'b1;
    end else if (rise) begin
      case (r_ff.st)
        dsc_pkg::DSC_D_IDLE: begin
          if (bitIn) begin
            if (r_ff.pre != `DSC_PRE_LEN) begin
              nxt_r.pre = r_ff.pre + 6'h01;
            end
          end else if (r_ff.pre == `DSC_PRE_LEN) begin
            nxt_r.st  = dsc_pkg::DSC_D_HDR;
            nxt_r.cnt = 5'h00;
            nxt_r.pre = 6'h00;
          end else begin
            nxt_r.pre = 6'h00;
          end
        end
        dsc_pkg::DSC_D_HDR: begin
          nxt_r.hdr = newHdr;
          nxt_r.cnt = r_ff.cnt + 5'h01;
          if (r_ff.cnt == `DSC_HDR_LAST) begin
            nxt_r.cnt = 5'h00;
            nxt_r.st  = dsc_pkg::DSC_D_IDLE;
            if (newHdr[12] && newHdr[9:5] == PHY_ADDR &&
                (newHdr[11:10] == `DSC_OP_WR || newHdr[11:10] == `DSC_OP_RD)) begin
              nxt_r.st     = dsc_pkg::DSC_D_TA;
              nxt_r.isRead = (newHdr[11:10] == `DSC_OP_RD);
              nxt_r.regAd  = newHdr[4:0];
              nxt_r.sh     = rdVal;
            end
          end
        end
        dsc_pkg::DSC_D_TA: begin
          nxt_r.cnt = r_ff.cnt + 5'h01;
          if (r_ff.cnt != `DSC_TA_LAST) begin
            if (r_ff.isRead) begin
              nxt_r.mdioOut = 1'b0;
              nxt_r.mdioOeN = 1'b0;
            end
          end else begin
            nxt_r.st  = dsc_pkg::DSC_D_DATA;
            nxt_r.cnt = 5'h00;
            if (r_ff.isRead) begin
              nxt_r.mdioOut = r_ff.sh[15];
              nxt_r.sh      = {r_ff.sh[14:0], 1'b0};
            end
          end
        end
        dsc_pkg::DSC_D_DATA: begin
          nxt_r.cnt = r_ff.cnt + 5'h01;
          if (r_ff.isRead) begin
            nxt_r.mdioOut = r_ff.sh[15];
            nxt_r.sh      = {r_ff.sh[14:0], 1'b0};
            if (r_ff.cnt == `DSC_DATA_LAST) begin
              nxt_r.mdioOeN = 1'b1;
              nxt_r.mdioOut = 1'b1;
              nxt_r.st      = dsc_pkg::DSC_D_IDLE;
            end
          end else begin
            nxt_r.sh = {r_ff.sh[14:0], bitIn};
            if (r_ff.cnt == `DSC_DATA_LAST) begin
              nxt_r.st = dsc_pkg::DSC_D_IDLE;
              if (r_ff.regAd == `DSC_REG_ANA2) begin
                nxt_r.ana2 = {r_ff.sh[14:0], bitIn};
              end else if (r_ff.regAd == `DSC_REG_STBY) begin
                nxt_r.stby = {r_ff.sh[14:0], bitIn} & `DSC_STBY_MASK;
              end
            end
          end
        end
        default: begin
          nxt_r.st = dsc_pkg::DSC_D_IDLE;
        end
      endcase
    end

    // ************************************************
    // ** standby control
    // ************************************************
    en    = r_ff.stby[`DSC_BIT_ENABLE];
    limit = r_ff.stby[`DSC_BIT_TDLY] ? DLY_LONG : DLY_MIN;
    // loss timer restarts on any energy; it saturates at the selected delay
    if (r_ff.enS2 || !en) begin
      nxt_r.lossCnt = 16'h0000;
    end else if (r_ff.lossCnt < limit) begin
      nxt_r.lossCnt = r_ff.lossCnt + 16'h0001;
    end
    lost = (r_ff.lossCnt >= limit);

    if (!en) begin
      nxt_r.indicator = 1'b1;
    end else begin
      nxt_r.indicator = r_ff.enS2 | ~lost;
    end

    // commanded entry latches; only rst clears it
    nxt_r.manLatch = r_ff.manLatch |
                     (en & r_ff.stby[`DSC_BIT_METHOD] &
                      r_ff.stby[`DSC_BIT_MANUAL]);
    // automatic entry after the delay, left again when energy returns
    autoSleep = en & ~r_ff.stby[`DSC_BIT_METHOD] & lost & ~r_ff.enS2;
    nxt_r.standby   = nxt_r.manLatch | autoSleep;
    nxt_r.slowSel   = nxt_r.standby & r_ff.ana2[`DSC_BIT_SLOWOSC];
    nxt_r.rxTermOff = r_ff.stby[`DSC_BIT_RXTOFF];

    // non-volatile copy tracks settings only while access is enabled
    nxt_r.shadowEn = r_ff.stby[`DSC_BIT_SHADOW];
    if (r_ff.stby[`DSC_BIT_SHADOW]) begin
      nxt_r.nvCopy = {r_ff.stby[6:0], r_ff.ana2[9:8], r_ff.ana2[1:0]};
    end
  end

  // ************************************************
  // ** state register
  // ************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_ff           <= '0;
      r_ff.st        <= dsc_pkg::DSC_D_IDLE;
      r_ff.stby      <= `DSC_RST_STBY;
      r_ff.ana2      <= `DSC_RST_ANA2;
      r_ff.indicator <= 1'b1;
      r_ff.mdioOut   <= 1'b1;
      r_ff.mdioOeN   <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ************************************************
  // ** outputs
  // ************************************************
  assign mg.devOut          = r_ff.mdioOut;
  assign mg.devOeN          = r_ff.mdioOeN;
  assign energyIndicatorOut = r_ff.indicator;
  assign standbyActive      = r_ff.standby;
  assign slowOscSel         = r_ff.slowSel;
  assign rxTermOff          = r_ff.rxTermOff;
  assign shadowEn           = r_ff.shadowEn;
  assign shadowWord         = r_ff.nvCopy;
endmodule

// ---- core/dsc_host.sv ----
// deep standby control, management host end: frame engine and reset pulse
// assumes: user commands come from logic on clk; mdio read back is async
`timescale 1ns/10ps
`include "dsc_cfg.svh"
module dsc_host #(
  parameter logic [4:0] PHY_ADDR = 5'h00,
  parameter logic [7:0] MDC_HALF = `DSC_MDC_HALF,
  parameter logic [7:0] RST_HOLD = `DSC_RST_HOLD
) (
  input  wire logic        clk,
  input  wire logic        rst,
  dsc_mdio_if.host         mg,
  input  wire logic        cmdValid,
  input  wire logic        cmdWrite,
  input  wire logic [4:0]  cmdReg,
  input  wire logic [15:0] cmdData,
  output logic             cmdReady,
  output logic             rdValid,
  output logic [15:0]      rdData,
  input  wire logic        resetReq,
  input  wire logic        partnerAutoNeg,
  input  wire logic        partnerCrossover,
  input  wire logic        link100,
  output logic             devReset
);
  if (MDC_HALF < `DSC_MDC_HALF || RST_HOLD == 8'h00) begin : gBadPar
    $error("dsc_host: mdc half period below 4 clocks or zero reset hold");
  end

  dsc_pkg::dsc_host_s_t r_ff;
  dsc_pkg::dsc_host_s_t nxt_r;
  logic [15:0] wrData;
  logic        autoCase;

  always_comb begin
    nxt_r        = r_ff;
    nxt_r.mdioS1 = mg.mdio;
    nxt_r.mdioS2 = r_ff.mdioS1;
    nxt_r.rdValid = 1'b0;
    wrData = cmdData;
    if (cmdReg == `DSC_REG_STBY && cmdData[`DSC_BIT_ENABLE]) begin
      wrData[`DSC_BIT_SHADOW] = 1'b1;
    end
    autoCase = cmdData[`DSC_BIT_ENABLE] & ~cmdData[`DSC_BIT_METHOD];
    // automatic method: minimum delay kept only for plain 100 links; otherwise lengthen
    if (cmdReg == `DSC_REG_STBY && autoCase &&
        (partnerAutoNeg || partnerCrossover || !link100)) begin
      wrData[`DSC_BIT_TDLY] = 1'b1;
    end
    case (r_ff.st)
      dsc_pkg::DSC_H_IDLE: begin
        if (resetReq) begin
          // commanded standby ends only with a hardware reset
          nxt_r.st       = dsc_pkg::DSC_H_RST;
          nxt_r.devReset = 1'b1;
          nxt_r.div      = 8'h00;
          nxt_r.cmdReady = 1'b0;
        end else if (cmdValid) begin
          nxt_r.st       = dsc_pkg::DSC_H_FRAME;
          nxt_r.cmdReady = 1'b0;
          nxt_r.isRead   = ~cmdWrite;
          nxt_r.frame    = {`DSC_START, cmdWrite ? `DSC_OP_WR : `DSC_OP_RD,
                            PHY_ADDR, cmdReg, `DSC_TA_WR, wrData};
          nxt_r.idx      = 6'h00;
          nxt_r.div      = 8'h00;
          nxt_r.mdc      = 1'b0;
          nxt_r.mdioOut  = 1'b1;
          nxt_r.mdioOeN  = 1'b0;
        end
      end
      dsc_pkg::DSC_H_FRAME: begin
        nxt_r.div = r_ff.div + 8'h01;
        if (r_ff.div == MDC_HALF - 8'h01) begin
          nxt_r.div = 8'h00;
          if (!r_ff.mdc) begin
            nxt_r.mdc = 1'b1;
            if (r_ff.isRead && r_ff.idx >= `DSC_DATA_IDX) begin
              nxt_r.rdData = {r_ff.rdData[14:0], r_ff.mdioS2};
            end
          end else begin
            nxt_r.mdc = 1'b0;
            nxt_r.idx = r_ff.idx + 6'h01;
            if (r_ff.idx == `DSC_FRAME_LAST) begin
              nxt_r.st       = dsc_pkg::DSC_H_IDLE;
              nxt_r.cmdReady = 1'b1;
              nxt_r.rdValid  = r_ff.isRead;
              nxt_r.mdioOeN  = 1'b1;
              nxt_r.mdioOut  = 1'b1;
            end else begin
              nxt_r.mdioOut = nxt_r.idx[5] ? r_ff.frame[5'h1F - nxt_r.idx[4:0]] : 1'b1;
              nxt_r.mdioOeN = r_ff.isRead && nxt_r.idx >= `DSC_TA_IDX;
            end
          end
        end
      end
      dsc_pkg::DSC_H_RST: begin
        nxt_r.div = r_ff.div + 8'h01;
        if (r_ff.div == RST_HOLD - 8'h01) begin
          nxt_r.st       = dsc_pkg::DSC_H_IDLE;
          nxt_r.devReset = 1'b0;
          nxt_r.cmdReady = 1'b1;
        end
      end
      default: begin
        nxt_r.st = dsc_pkg::DSC_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_ff          <= '0;
      r_ff.st       <= dsc_pkg::DSC_H_IDLE;
      r_ff.mdioOut  <= 1'b1;
      r_ff.mdioOeN  <= 1'b1;
      r_ff.cmdReady <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign mg.mdc     = r_ff.mdc;
  assign mg.hostOut = r_ff.mdioOut;
  assign mg.hostOeN = r_ff.mdioOeN;
  assign cmdReady   = r_ff.cmdReady;
  assign rdValid    = r_ff.rdValid;
  assign rdData     = r_ff.rdData;
  assign devReset   = r_ff.devReset;
endmodule

// ---- sim/dsc_assertions.sv ----
// checker for the standby outputs of the device end
// assumes: instanced in tb beside the link; rst is the device's reset
`timescale 1ns/10ps
module dsc_assertions (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        energyDetect,
  input wire logic        energyIndicatorOut,
  input wire logic        standbyActive,
  input wire logic        slowOscSel,
  input wire logic        rxTermOff,
  input wire logic        shadowEn,
  input wire logic [10:0] shadowWord,
  input wire logic        devOeN
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence cmdEntry;
    $rose(standbyActive) && energyIndicatorOut && shadowEn;
  endsequence
  sequence forcedTrue;
    (shadowEn && !shadowWord[7]) [*4];
  endsequence
  sequence frozenHeld;
    (standbyActive && !slowOscSel) [*2];
  endsequence

  chk_ind_follow: assert property (energyDetect [*5] |-> energyIndicatorOut)
    else $error("indicator low with energy present");
  chk_ind_delay: assert property ($fell(energyIndicatorOut) |-> !$past(energyDetect, 9))
    else $error("indicator dropped too early");
  chk_ind_forced: assert property (forcedTrue |-> energyIndicatorOut && !standbyActive)
    else $error("indicator not forced true");
  chk_stby_exit: assert property ($fell(standbyActive) |-> energyIndicatorOut)
    else $error("standby left without energy");
  chk_man_entry: assert property (cmdEntry |-> shadowWord[10:9] == 2'h3)
    else $error("standby entered without manual request");
  chk_slow_sel: assert property ($rose(slowOscSel) |-> standbyActive)
    else $error("slow clock outside standby");
  chk_rx_term: assert property ((shadowEn && $stable(rxTermOff)) [*3]
    |-> rxTermOff == shadowWord[6])
    else $error("termination disagrees with control bit");
  chk_shadow_hold: assert property (!shadowEn [*3] |-> $stable(shadowWord))
    else $error("shadow copy changed while disabled");
  chk_frozen_quiet: assert property (frozenHeld |-> devOeN)
    else $error("device drives link while its clock is stopped");
endmodule

// ---- sim/tb.sv ----
// self-checking bench: host end and device end joined by the link
// assumes: host devReset also resets the device end
`timescale 1ns/10ps
module tb;
  logic        clk;
  logic        rst;
  logic        devRst;
  logic        cmdValid;
  logic        cmdWrite;
  logic [4:0]  cmdReg;
  logic [15:0] cmdData;
  logic        cmdReady;
  logic        rdValid;
  logic [15:0] rdData;
  logic        resetReq;
  logic        partnerAutoNeg;
  logic        partnerCrossover;
  logic        link100;
  logic        devReset;
  logic        energyDetect;
  logic        energyIndicatorOut;
  logic        standbyActive;
  logic        slowOscSel;
  logic        rxTermOff;
  logic        shadowEn;
  logic [10:0] shadowWord;
  int          miscompares;
  int          numChecks;
  int          cycles;

  // ****************************************
  // design and checker
  // ****************************************
  assign devRst = rst | devReset;
  dsc_mdio_if mgIf ();
  dsc_host #(.RST_HOLD(8'h04)) dsc_host_i (.clk(clk), .rst(rst), .mg(mgIf),
    .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdReg(cmdReg), .cmdData(cmdData),
    .cmdReady(cmdReady), .rdValid(rdValid), .rdData(rdData), .resetReq(resetReq),
    .partnerAutoNeg(partnerAutoNeg), .partnerCrossover(partnerCrossover),
    .link100(link100), .devReset(devReset));
  dsc_device #(.DLY_MIN(16'h0008), .DLY_LONG(16'h0040)) dsc_device_i (.clk(clk),
    .rst(devRst), .mg(mgIf), .energyDetect(energyDetect),
    .energyIndicatorOut(energyIndicatorOut), .standbyActive(standbyActive),
    .slowOscSel(slowOscSel), .rxTermOff(rxTermOff), .shadowEn(shadowEn),
    .shadowWord(shadowWord));
  dsc_assertions chk_i (.clk(clk), .rst(devRst), .energyDetect(energyDetect),
    .energyIndicatorOut(energyIndicatorOut), .standbyActive(standbyActive),
    .slowOscSel(slowOscSel), .rxTermOff(rxTermOff), .shadowEn(shadowEn),
    .shadowWord(shadowWord), .devOeN(mgIf.devOeN));

  // ****************************************
  // shared tasks
  // ****************************************
  always #12.5 clk = ~clk;

  task automatic final_report();
    if (miscompares == 0 && numChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    numChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one management frame; read data kept from the rdValid cycle
  task automatic xfer(input logic wr, input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] rd);
    int n;
    n = 0;
    rd = 16'h0000;
    @(negedge clk);
    cmdValid = 1'h1;
    cmdWrite = wr;
    cmdReg = ra;
    cmdData = wd;
    @(negedge clk);
    cmdValid = 1'h0;
    while (cmdReady !== 1'h1 && n < 700) begin
      @(negedge clk);
      n++;
      if (rdValid === 1'h1) rd = rdData;
    end
    check(16'(cmdReady), 16'h0001);
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] v;
    xfer(1'h1, ra, wd, v);
  endtask

  task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] v;
    xfer(1'h0, ra, 16'h0000, v);
    check(v, exp);
  endtask

  // drop energy and time the indicator's fall
  task automatic lose(input int lo, input int hi);
    int n;
    n = 0;
    energyDetect = 1'h0;
    while (energyIndicatorOut === 1'h1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check(16'(n >= lo && n <= hi), 16'h0001);
    check(16'(standbyActive), 16'h0001);
    energyDetect = 1'h1;
    repeat (6) @(negedge clk);
    check(16'(energyIndicatorOut), 16'h0001);
    check(16'(standbyActive), 16'h0000);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_vals();
    rd_chk(5'h14, 16'h0000);
    rd_chk(5'h13, 16'h0000);
    check(16'(energyIndicatorOut), 16'h0001);
  endtask

  task automatic t_fields();
    wr(5'h14, 16'h0014);
    rd_chk(5'h14, 16'h0014);
    check(16'(rxTermOff), 16'h0001);
    check(16'(shadowEn), 16'h0001);
    wr(5'h14, 16'hFFDF);
    rd_chk(5'h14, 16'h005F);
    wr(5'h13, 16'h0303);
    rd_chk(5'h13, 16'h0303);
    check(16'(shadowWord), 16'h05FF);
    wr(5'h15, 16'h1234);
    rd_chk(5'h15, 16'h0000);
    wr(5'h14, 16'h0000);
    check(16'(rxTermOff), 16'h0000);
    check(16'(shadowEn), 16'h0000);
    check(16'(shadowWord), 16'h05FF);
  endtask

  task automatic t_auto();
    wr(5'h14, 16'h0008);
    rd_chk(5'h14, 16'h0018);
    lose(8, 14);
    partnerAutoNeg = 1'h1;
    wr(5'h14, 16'h0008);
    rd_chk(5'h14, 16'h001A);
    lose(64, 72);
    partnerAutoNeg = 1'h0;
    partnerCrossover = 1'h1;
    wr(5'h14, 16'h0008);
    rd_chk(5'h14, 16'h001A);
    partnerCrossover = 1'h0;
    link100 = 1'h0;
    wr(5'h14, 16'h0008);
    rd_chk(5'h14, 16'h001A);
    wr(5'h14, 16'h0048);
    rd_chk(5'h14, 16'h0058);
    link100 = 1'h1;
  endtask

  task automatic t_disabled();
    wr(5'h14, 16'h0010);
    energyDetect = 1'h0;
    repeat (100) @(negedge clk);
    check(16'(energyIndicatorOut), 16'h0001);
    check(16'(standbyActive), 16'h0000);
    energyDetect = 1'h1;
  endtask

  task automatic t_manual();
    wr(5'h13, 16'h0001);
    wr(5'h14, 16'h0038);
    repeat (10) @(negedge clk);
    check(16'(standbyActive), 16'h0000);
    wr(5'h14, 16'h0078);
    repeat (4) @(negedge clk);
    check(16'(standbyActive), 16'h0001);
    check(16'(slowOscSel), 16'h0001);
    energyDetect = 1'h0;
    repeat (100) @(negedge clk);
    energyDetect = 1'h1;
    repeat (10) @(negedge clk);
    check(16'(standbyActive), 16'h0001);
    rd_chk(5'h14, 16'h0078);
    resetReq = 1'h1;
    @(negedge clk);
    resetReq = 1'h0;
    repeat (12) @(negedge clk);
    check(16'(standbyActive), 16'h0000);
    rd_chk(5'h14, 16'h0000);
    rd_chk(5'h13, 16'h0000);
  endtask

  initial begin
    clk = 1'h0;
    rst = 1'h1;
    cmdValid = 1'h0;
    cmdWrite = 1'h0;
    cmdReg = 5'h00;
    cmdData = 16'h0000;
    resetReq = 1'h0;
    partnerAutoNeg = 1'h0;
    partnerCrossover = 1'h0;
    link100 = 1'h1;
    energyDetect = 1'h1;
    miscompares = 0;
    numChecks = 0;
    cycles = 0;
    repeat (20) @(negedge clk);
    rst = 1'h0;
    t_reset_vals();
    t_fields();
    t_auto();
    t_disabled();
    t_manual();
    final_report();
  end
endmodule
